// *** hw/isp_pkg.sv ***
package isp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction register
	localparam int IR_W = 5;
	localparam logic [4:0] INS_PRELOAD = 5'h02;
	localparam logic [4:0] INS_ENABLE = 5'h09;
	localparam logic [4:0] INS_ERASE = 5'h0a;
	localparam logic [4:0] INS_PROGRAM = 5'h0b;
	localparam logic [4:0] INS_VERIFY = 5'h0c;
	localparam logic [4:0] INS_DISABLE = 5'h10;
	localparam logic [4:0] INS_BYPASS = 5'h1f;
	// Fixed pattern loaded into the instruction shifter at capture
	localparam logic [4:0] IR_CAPTURE = 5'h01;
	localparam logic [4:0] IR_RESET = INS_BYPASS;

	////////////////////////////////////////////////////////////////////////////////
	// Array and boundary sizes
	localparam int ROWS_DEF = 4;
	localparam int ROW_W_DEF = 8;
	localparam int BS_W_DEF = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TCK_MAX_HZ = 10_000_000;
	localparam int ERASE_PW_MS = 100;
	localparam int PROGRAM_PW_MS = 10;
	localparam int ERASE_PW_CYC = ERASE_PW_MS * (CLK_HZ / 1000);
	localparam int PROGRAM_PW_CYC = PROGRAM_PW_MS * (CLK_HZ / 1000);
	localparam int TCK_DIV_DEF = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Mode-select walks, first bit in bit 0
	localparam logic [7:0] RESET_TMS_ONES = 8'h05;
	localparam logic [3:0] IR_HDR = 4'h3;
	localparam logic [7:0] IR_HDR_LEN = 8'h04;
	localparam logic [3:0] DR_HDR = 4'h1;
	localparam logic [7:0] DR_HDR_LEN = 8'h03;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} tap_t;

	typedef enum logic [2:0] {
		OP_ENABLE, OP_ERASE, OP_PROGRAM, OP_VERIFY, OP_DISABLE, OP_PRELOAD, OP_BYPASS
	} op_t;

endpackage

// *** hw/isp_link_if.sv ***
`timescale 1ns/1ps
interface isp_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	modport device (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport programmer (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// *** hw/isp_device.sv ***
`timescale 1ns/1ps
module isp_device
	import isp_pkg::*;
#(
	parameter int ROWS = ROWS_DEF,
	parameter int ROW_W = ROW_W_DEF,
	parameter int BS_W = BS_W_DEF
)
(
	// Test access port, all on the link clock
	isp_link_if.device link,
	// Power-up reset
	input wire logic rst_n,
	// System logic
	input wire logic [BS_W-1:0] core_out,
	output logic [BS_W-1:0] pin_out,
	output logic isp_active,
	output logic [ROWS-1:0][ROW_W-1:0] cfg_array
);

	localparam int ADDR_W = (ROWS > 1) ? $clog2(ROWS) : 1;
	localparam int DR_W = ADDR_W + ROW_W;

	if (ROWS < 2 || ROW_W < 1 || BS_W < 1)
	begin : g_check
		$error("isp_device: ROWS must be at least 2, widths at least 1");
	end

	typedef struct packed {
		tap_t tap;
		logic [IR_W-1:0] ir_sr;
		logic [IR_W-1:0] ir;
		logic isp;
		logic bypass;
		logic [DR_W-1:0] pd_sr;
		logic [BS_W-1:0] bs_sr;
		logic [BS_W-1:0] bs_hold;
		logic [BS_W-1:0] core_s1;
		logic [BS_W-1:0] core_s2;
		logic [BS_W-1:0] pins;
		logic [ROWS-1:0][ROW_W-1:0] arr;
	} dev_state_t;

	dev_state_t q;
	dev_state_t d;
	logic isp_sel;
	logic bs_sel;
	logic hold_pins;
	logic [ADDR_W-1:0] row_addr;
	logic row_ok;
	logic tdo_q;
	logic tdo_oe_q;
	logic serial_bit;

	////////////////////////////////////////////////////////////////////////////////
	// Register selection from the active instruction

	always_comb
	begin
		isp_sel = (q.ir == INS_ENABLE) || (q.ir == INS_ERASE) || (q.ir == INS_PROGRAM)
			|| (q.ir == INS_VERIFY) || (q.ir == INS_DISABLE);
		bs_sel = (q.ir == INS_PRELOAD);
		row_addr = q.pd_sr[DR_W-1:ROW_W];
		// Rows past the end are ignored when ROWS is not a power of two
		row_ok = (32'(row_addr) < ROWS);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Controller state walk and register actions

	always_comb
	begin
		d = q;
		d.core_s1 = core_out;
		d.core_s2 = q.core_s1;

		case (q.tap)
			TAP_RESET:
				d.tap = link.tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:
				d.tap = link.tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:
				d.tap = link.tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:
				d.tap = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR:
				d.tap = link.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR:
				d.tap = link.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR:
				d.tap = link.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR:
				d.tap = link.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:
				d.tap = link.tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:
				d.tap = link.tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:
				d.tap = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR:
				d.tap = link.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR:
				d.tap = link.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR:
				d.tap = link.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR:
				d.tap = link.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:
				d.tap = link.tms ? TAP_SEL_DR : TAP_IDLE;
			default:
				d.tap = TAP_RESET;
		endcase

		case (q.tap)
			TAP_RESET:
			begin
				d.ir = IR_RESET;
			end
			TAP_CAP_IR:
			begin
				d.ir_sr = IR_CAPTURE;
			end
			TAP_SHIFT_IR:
			begin
				d.ir_sr = {link.tdi, q.ir_sr[IR_W-1:1]};
			end
			TAP_UPD_IR:
			begin
				// Whole code acts only once the scan is complete
				d.ir = q.ir_sr;
				if (q.ir_sr == INS_ENABLE)
				begin
					d.isp = 1'b1;
				end
				else if (q.ir_sr == INS_ERASE && q.isp)
				begin
					d.arr = '0;
				end
				else if (q.ir_sr == INS_DISABLE)
				begin
					d.isp = 1'b0;
				end
			end
			TAP_CAP_DR:
			begin
				// The programming shifter keeps its contents so verify data survives
				if (bs_sel)
				begin
					d.bs_sr = q.core_s2;
				end
				else if (!isp_sel)
				begin
					d.bypass = 1'b0;
				end
			end
			TAP_SHIFT_DR:
			begin
				if (isp_sel)
				begin
					d.pd_sr = {link.tdi, q.pd_sr[DR_W-1:1]};
				end
				else if (bs_sel)
				begin
					d.bs_sr = {link.tdi, q.bs_sr[BS_W-1:1]};
				end
				else
				begin
					d.bypass = link.tdi;
				end
			end
			TAP_UPD_DR:
			begin
				if (bs_sel)
				begin
					d.bs_hold = q.bs_sr;
				end
				else if (q.ir == INS_PROGRAM && q.isp && row_ok)
				begin
					d.arr[row_addr] = q.pd_sr[ROW_W-1:0];
				end
				else if (q.ir == INS_VERIFY && q.isp && row_ok)
				begin
					d.pd_sr[ROW_W-1:0] = q.arr[row_addr];
				end
			end
			default:
			begin
			end
		endcase

		// Outputs stay frozen for the arming and array operations only.
		// Decided from the next instruction, since the link clock may stop right after update.
		hold_pins = d.isp && ((d.ir == INS_ENABLE) || (d.ir == INS_ERASE)
			|| (d.ir == INS_PROGRAM) || (d.ir == INS_VERIFY));
		d.pins = hold_pins ? d.bs_hold : q.core_s2;
	end

	always_ff @(posedge link.tck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '{tap: TAP_RESET, ir: IR_RESET, default: '0};
		end
		else
		begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial output, launched on the falling edge

	always_comb
	begin
		if (q.tap == TAP_SHIFT_IR)
		begin
			serial_bit = q.ir_sr[0];
		end
		else if (isp_sel)
		begin
			serial_bit = q.pd_sr[0];
		end
		else if (bs_sel)
		begin
			serial_bit = q.bs_sr[0];
		end
		else
		begin
			serial_bit = q.bypass;
		end
	end

	// Half a clock of margin for the far end to sample on the next rise
	always_ff @(negedge link.tck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end
		else
		begin
			tdo_q <= serial_bit;
			tdo_oe_q <= (q.tap == TAP_SHIFT_IR) || (q.tap == TAP_SHIFT_DR);
		end
	end

	assign link.tdo = tdo_q;
	assign link.tdo_oe = tdo_oe_q;
	assign pin_out = q.pins;
	assign isp_active = q.isp;
	assign cfg_array = q.arr;

endmodule

// *** hw/isp_programmer.sv ***
`timescale 1ns/1ps
module isp_programmer
	import isp_pkg::*;
#(
	parameter int ROWS = ROWS_DEF,
	parameter int ROW_W = ROW_W_DEF,
	parameter int BS_W = BS_W_DEF,
	parameter int TCK_DIV = TCK_DIV_DEF,
	parameter int ERASE_CYC = ERASE_PW_CYC,
	parameter int PROGRAM_CYC = PROGRAM_PW_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command
	input wire logic cmd_valid,
	input wire op_t cmd_op,
	input wire logic [((ROWS > 1) ? $clog2(ROWS) : 1)-1:0] cmd_addr,
	input wire logic [ROW_W-1:0] cmd_data,
	input wire logic [BS_W-1:0] cmd_bs,
	output logic cmd_ready,
	// Answer
	output logic resp_valid,
	output logic [ROW_W-1:0] resp_data,
	output logic resp_match,
	// Test access port
	isp_link_if.programmer link
);

	localparam int ADDR_W = (ROWS > 1) ? $clog2(ROWS) : 1;
	localparam int DR_W = ADDR_W + ROW_W;
	localparam int SR_W = (DR_W > BS_W) ? DR_W : BS_W;
	localparam int DIV_W = $clog2(TCK_DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TCK_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(TCK_DIV / 2);

	if (TCK_DIV < 8 || TCK_DIV % 2 != 0 || CLK_HZ / TCK_DIV > TCK_MAX_HZ
		|| SR_W > 255 || ROWS < 2 || ERASE_CYC < 1 || PROGRAM_CYC < 1)
	begin : g_check
		$error("isp_programmer: unsupported parameter values");
	end

	typedef enum logic [2:0] {H_RESET, H_IDLE, H_HDR, H_SHIFT, H_TAIL, H_WAIT, H_DONE} hst_t;

	typedef struct packed {
		hst_t st;
		logic [DIV_W-1:0] div;
		logic tck;
		logic tms;
		logic tdi;
		logic live;
		logic cap;
		logic [7:0] cnt;
		logic [7:0] len;
		logic is_dr;
		logic pass;
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [ROW_W-1:0] data;
		logic [BS_W-1:0] bs;
		logic [SR_W-1:0] sr;
		logic [SR_W-1:0] rx;
		logic [31:0] wait_cnt;
		logic s1;
		logic s2;
		logic ready;
		logic rvalid;
		logic [ROW_W-1:0] rdata;
		logic match;
	} host_state_t;

	host_state_t q;
	host_state_t d;
	logic [SR_W-1:0] dr_load;
	logic [7:0] dr_len;
	logic [ROW_W-1:0] rx_data;

	function automatic logic [IR_W-1:0] ir_code(input op_t op);
		case (op)
			OP_ENABLE: ir_code = INS_ENABLE;
			OP_ERASE: ir_code = INS_ERASE;
			OP_PROGRAM: ir_code = INS_PROGRAM;
			OP_VERIFY: ir_code = INS_VERIFY;
			OP_DISABLE: ir_code = INS_DISABLE;
			OP_PRELOAD: ir_code = INS_PRELOAD;
			default: ir_code = INS_BYPASS;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Scan sequencer; one step per divided clock period

	always_comb
	begin
		dr_load = (q.op == OP_PRELOAD) ? SR_W'(q.bs)
			: SR_W'({q.addr, (q.op == OP_PROGRAM) ? q.data : ROW_W'(0)});
		dr_len = (q.op == OP_PRELOAD) ? 8'(BS_W) : 8'(DR_W);
		rx_data = q.rx[SR_W-DR_W +: ROW_W];

		d = q;
		d.s1 = link.tdo;
		d.s2 = q.s1;
		d.rvalid = 1'b0;
		d.div = (q.div == DIV_LAST) ? '0 : DIV_W'(q.div + 1'b1);

		// Rise: device has launched its bit TCK_DIV/2 + 1 system clocks ago
		if (q.div == DIV_HALF)
		begin
			d.tck = q.live;
			if (q.live && q.cap)
			begin
				d.rx = {q.s2, q.rx[SR_W-1:1]};
			end
		end

		// Fall: present the next step's mode and data bits
		if (q.div == DIV_LAST)
		begin
			d.tck = 1'b0;
			d.live = 1'b0;
			d.cap = 1'b0;
			case (q.st)
				H_RESET:
				begin
					d.live = 1'b1;
					d.tms = (q.cnt < RESET_TMS_ONES);
					d.cnt = q.cnt + 8'd1;
					if (q.cnt == RESET_TMS_ONES)
					begin
						d.st = H_IDLE;
						d.ready = 1'b1;
						d.cnt = '0;
					end
				end
				H_HDR:
				begin
					d.live = 1'b1;
					d.tms = q.is_dr ? DR_HDR[q.cnt[1:0]] : IR_HDR[q.cnt[1:0]];
					d.cnt = q.cnt + 8'd1;
					if (q.cnt == (q.is_dr ? DR_HDR_LEN : IR_HDR_LEN) - 8'd1)
					begin
						d.st = H_SHIFT;
						d.cnt = '0;
					end
				end
				H_SHIFT:
				begin
					d.live = 1'b1;
					d.cap = 1'b1;
					d.tdi = q.sr[0];
					d.sr = q.sr >> 1;
					d.tms = (q.cnt == q.len - 8'd1);
					d.cnt = q.cnt + 8'd1;
					if (q.cnt == q.len - 8'd1)
					begin
						d.st = H_TAIL;
						d.cnt = '0;
					end
				end
				H_TAIL:
				begin
					d.live = 1'b1;
					d.tms = (q.cnt == 8'd0);
					d.cnt = q.cnt + 8'd1;
					if (q.cnt == 8'd1)
					begin
						d.cnt = '0;
						if (!q.is_dr && (q.op == OP_PROGRAM || q.op == OP_VERIFY
							|| q.op == OP_PRELOAD))
						begin
							d.is_dr = 1'b1;
							d.st = H_HDR;
							d.sr = dr_load;
							d.len = dr_len;
						end
						else if (!q.is_dr && q.op == OP_ERASE)
						begin
							d.st = H_WAIT;
							d.wait_cnt = 32'(ERASE_CYC);
						end
						else if (q.is_dr && q.op == OP_VERIFY && !q.pass)
						begin
							// Second scan reads back what the first one addressed
							d.pass = 1'b1;
							d.st = H_HDR;
							d.sr = dr_load;
						end
						else if (q.is_dr && q.op == OP_PROGRAM)
						begin
							d.st = H_WAIT;
							d.wait_cnt = 32'(PROGRAM_CYC);
						end
						else
						begin
							d.st = H_DONE;
						end
					end
				end
				default:
				begin
				end
			endcase
		end

		// Clock is parked low outside scans, device rests in idle
		case (q.st)
			H_IDLE:
			begin
				if (cmd_valid && q.ready)
				begin
					d.ready = 1'b0;
					d.op = cmd_op;
					d.addr = cmd_addr;
					d.data = cmd_data;
					d.bs = cmd_bs;
					d.sr = SR_W'(ir_code(cmd_op));
					d.len = 8'(IR_W);
					d.is_dr = 1'b0;
					d.pass = 1'b0;
					d.cnt = '0;
					d.st = H_HDR;
				end
			end
			H_WAIT:
			begin
				d.wait_cnt = q.wait_cnt - 32'd1;
				if (q.wait_cnt == 32'd1)
				begin
					d.st = H_DONE;
				end
			end
			H_DONE:
			begin
				// The update acts on the last rise of the tail, so answer only after it
				if (q.div == DIV_LAST)
				begin
					d.rvalid = 1'b1;
					d.rdata = rx_data;
					d.match = (q.op == OP_VERIFY) && (rx_data == q.data);
					d.ready = 1'b1;
					d.st = H_IDLE;
				end
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '{st: H_RESET, op: OP_BYPASS, default: '0};
		end
		else
		begin
			q <= d;
		end
	end

	assign link.tck = q.tck;
	assign link.tms = q.tms;
	assign link.tdi = q.tdi;
	assign cmd_ready = q.ready;
	assign resp_valid = q.rvalid;
	assign resp_data = q.rdata;
	assign resp_match = q.match;

endmodule

// *** test/jtag_isp_eeprom_programming_chk.sv ***
`timescale 1ns/1ps
module jtag_isp_eeprom_programming_chk
	import isp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	// Device state
	input wire logic isp_active
);
	typedef struct packed {tap_t st; logic [4:0] sh; logic [4:0] ir; logic [2:0] n; logic live;} mon_t;
	mon_t mon_q, mon_d;

	function automatic tap_t nxt(input tap_t s, input logic m);
		case (s)
			TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR, TAP_SHIFT_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: return m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: return m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR, TAP_SHIFT_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: return m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			default: return m ? TAP_UPD_IR : TAP_SHIFT_IR;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Shadow controller; instruction taken on entry to update so a same-edge act still sees it
	always_comb
	begin
		mon_d = mon_q;
		mon_d.live = 1'b1;
		mon_d.st = nxt(mon_q.st, tms);
		if (mon_q.st == TAP_CAP_IR)
			mon_d.n = 3'h0;
		if (mon_q.st == TAP_SHIFT_IR)
		begin
			mon_d.sh = {tdi, mon_q.sh[4:1]};
			mon_d.n = mon_q.n + 3'h1;
		end
		if (mon_d.st == TAP_UPD_IR)
			mon_d.ir = mon_d.sh;
	end

	always_ff @(posedge tck or negedge rst_n)
	begin
		if (!rst_n)
			mon_q <= '{TAP_RESET, 5'h00, IR_RESET, 3'h0, 1'b0};
		else
			mon_q <= mon_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Programmer side, seen on the system clock
	property p_tms_low;
		@(posedge clk) disable iff (!rst_n) $changed(tms) |-> !tck;
	endproperty
	a_tms_low: assert property (p_tms_low) else $error("tms moved while tck high");
	property p_tdi_low;
		@(posedge clk) disable iff (!rst_n) $changed(tdi) |-> !tck;
	endproperty
	a_tdi_low: assert property (p_tdi_low) else $error("tdi moved while tck high");
	// High phase is TCK_DIV/2 - 1 system clocks with the default divider of 8
	property p_tck_high;
		@(posedge clk) disable iff (!rst_n) $rose(tck) |-> tck [*3] ##1 !tck;
	endproperty
	a_tck_high: assert property (p_tck_high) else $error("tck high phase wrong");
	property p_tdo_fall;
		@(posedge clk) disable iff (!rst_n) $changed(tdo) |-> $fell(tck);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off tck fall");

	////////////////////////////////////////////////////////////////////////////////
	// Device side, seen on the link clock
	property p_oe_shift;
		@(posedge tck) disable iff (!rst_n)
			tdo_oe == (mon_q.st inside {TAP_SHIFT_DR, TAP_SHIFT_IR});
	endproperty
	a_oe_shift: assert property (p_oe_shift) else $error("tdo_oe outside shift");
	property p_ir_capture;
		@(posedge tck) disable iff (!rst_n)
			mon_q.st == TAP_SHIFT_IR && mon_q.n < 3'h5 |-> tdo == IR_CAPTURE[mon_q.n];
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("bad instruction capture");
	property p_arm;
		@(posedge tck) disable iff (!rst_n) mon_q.live && $rose(isp_active) |-> mon_q.ir == INS_ENABLE;
	endproperty
	a_arm: assert property (p_arm) else $error("armed without enable");
	property p_disarm;
		@(posedge tck) disable iff (!rst_n) mon_q.live && $fell(isp_active) |-> mon_q.ir == INS_DISABLE;
	endproperty
	a_disarm: assert property (p_disarm) else $error("left mode without disable");

	c_arm: cover property (@(posedge tck) $rose(isp_active));
	c_erase: cover property (@(posedge tck) mon_q.st == TAP_UPD_IR && mon_q.ir == INS_ERASE);
	c_disarm: cover property (@(posedge tck) $fell(isp_active));
endmodule

// *** test/jtag_isp_eeprom_programming_test.sv ***
`timescale 1ns/1ps
module jtag_isp_eeprom_programming_test
	import isp_pkg::*;
;
	typedef struct {op_t op; logic [1:0] a; logic [7:0] d; logic [7:0] bs; logic [7:0] core; logic act;} row_t;
	// Refused program rows sit before enable and after disable, the refused erase row after disable
	row_t rows[14] = '{
		'{OP_PRELOAD, 2'h0, 8'h00, 8'ha5, 8'h96, 1'b0}, '{OP_PROGRAM, 2'h1, 8'h3c, 8'h00, 8'h96, 1'b0},
		'{OP_ENABLE, 2'h0, 8'h00, 8'h00, 8'h69, 1'b1}, '{OP_PROGRAM, 2'h0, 8'h5a, 8'h00, 8'h69, 1'b1},
		'{OP_PROGRAM, 2'h3, 8'hc3, 8'h00, 8'h0f, 1'b1}, '{OP_VERIFY, 2'h3, 8'hc3, 8'h00, 8'h0f, 1'b1},
		'{OP_VERIFY, 2'h0, 8'hff, 8'h00, 8'h0f, 1'b1}, '{OP_ERASE, 2'h0, 8'h00, 8'h00, 8'hf0, 1'b1},
		'{OP_VERIFY, 2'h0, 8'h00, 8'h00, 8'hf0, 1'b1}, '{OP_PROGRAM, 2'h2, 8'h81, 8'h00, 8'hf0, 1'b1},
		'{OP_DISABLE, 2'h0, 8'h00, 8'h00, 8'h33, 1'b0}, '{OP_PROGRAM, 2'h1, 8'h77, 8'h00, 8'h33, 1'b0},
		'{OP_ERASE, 2'h0, 8'h00, 8'h00, 8'h55, 1'b0}, '{OP_BYPASS, 2'h0, 8'h00, 8'h00, 8'hcc, 1'b0}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	op_t cmd_op = OP_BYPASS;
	logic [1:0] cmd_addr = 2'h0;
	logic [7:0] cmd_data = 8'h00, cmd_bs = 8'h00, core_out = 8'h00, resp_data, pin_out, held;
	logic cmd_ready, resp_valid, resp_match, isp_active, armed, frozen;
	logic [3:0][7:0] cfg_array, model;
	int miscompares = 0, check_count = 0;

	isp_link_if link();
	isp_device i_isp_device(.link(link), .rst_n(rst_n), .core_out(core_out), .pin_out(pin_out),
		.isp_active(isp_active), .cfg_array(cfg_array));
	isp_programmer #(.ERASE_CYC(20), .PROGRAM_CYC(10)) i_isp_programmer(.clk(clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_bs(cmd_bs), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
		.resp_match(resp_match), .link(link));
	jtag_isp_eeprom_programming_chk i_link_chk(.clk(clk), .rst_n(rst_n), .tck(link.tck),
		.tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe), .isp_active(isp_active));

	initial forever #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wait_hi(ref logic sig, input string what);
		for (int n = 0; n < 4000 && sig !== 1'b1; n++)
			@(posedge clk) #1;
		if (sig !== 1'b1)
		begin
			miscompares++;
			$display("unexpected at %0t: no %s", $time, what);
			close_out();
		end
	endtask

	task automatic run(input row_t r);
		@(posedge clk);
		cmd_op <= r.op;
		cmd_addr <= r.a;
		cmd_data <= r.d;
		cmd_bs <= r.bs;
		core_out <= r.core;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_hi(resp_valid, "response");
		case (r.op)
			OP_ENABLE: armed = 1'b1;
			OP_DISABLE: armed = 1'b0;
			OP_ERASE: if (armed) model = '0;
			OP_PROGRAM: if (armed) model[r.a] = r.d;
			OP_PRELOAD: held = r.bs;
			default: ;
		endcase
		frozen = armed && r.op inside {OP_ENABLE, OP_ERASE, OP_PROGRAM, OP_VERIFY};
		check(isp_active, r.act, "active");
		check(cfg_array, model, "array");
		check(pin_out, frozen ? held : r.core, "pins");
		check(resp_match, r.op == OP_VERIFY && model[r.a] == r.d, "match");
		if (r.op == OP_VERIFY)
			check(resp_data, model[r.a], "readback");
		wait_hi(cmd_ready, "ready");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		model = '0;
		armed = 1'b0;
		held = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wait_hi(cmd_ready, "ready");
		foreach (rows[i])
			run(rows[i]);
		// Reset in mid-run must clear the test logic without a test reset pin
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk) #1;
		check(isp_active, 1'b0, "reset active");
		check(link.tdo_oe, 1'b0, "reset oe");
		check(link.tck, 1'b0, "reset tck");
		check(cfg_array, 32'h0, "reset array");
		model = '0;
		armed = 1'b0;
		held = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wait_hi(cmd_ready, "ready");
		run('{OP_ENABLE, 2'h0, 8'h00, 8'h00, 8'h18, 1'b1});
		run('{OP_VERIFY, 2'h2, 8'h00, 8'h00, 8'h18, 1'b1});
		close_out();
	end
endmodule
